/* rtl/mrs_pkg.sv */
package mrs_pkg;

  // timing: link rate, character size and the silent gap in tenths of a character
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned BAUD_DEF      = 9600;
  localparam int unsigned CHAR_BITS     = 11;
  localparam int unsigned GAP_CHAR_X10  = 35;
  localparam longint      GAP_NUM       = longint'(CLK_HZ) * CHAR_BITS * GAP_CHAR_X10;
  localparam longint      GAP_DEN       = longint'(BAUD_DEF) * 10;
  // least time, so round up
  localparam int unsigned GAP_CYCLES_DEF = int'((GAP_NUM + GAP_DEN - 1) / GAP_DEN);

  // frame layout
  localparam logic [7:0]  ADDR_BCAST     = 8'h00;
  localparam logic [7:0]  ADDR_UNIT_MIN  = 8'h01;
  localparam logic [7:0]  ADDR_UNIT_MAX  = 8'h1F;
  localparam logic [8:0]  MSG_LEN_MAX    = 9'h100;
  localparam logic [8:0]  MSG_LEN_MIN    = 9'h004;
  localparam logic [8:0]  QUERY_LEN      = 9'h008;
  localparam int unsigned QBUF_BYTES     = 8;

  // function codes and exception handling
  localparam logic [7:0]  FC_READ        = 8'h03;
  localparam logic [7:0]  FC_WRITE       = 8'h06;
  localparam logic [7:0]  FC_DIAG        = 8'h08;
  localparam logic [7:0]  FC_EXC_FLAG    = 8'h80;
  localparam logic [7:0]  EXC_FUNC       = 8'h01;
  localparam logic [7:0]  EXC_ADDR       = 8'h02;
  localparam logic [7:0]  EXC_DATA       = 8'h03;
  localparam logic [7:0]  EXC_SLAVE      = 8'h04;
  localparam logic [7:0]  CERR_DATA      = 8'hE1;
  localparam logic [7:0]  CERR_DISABLED  = 8'hE2;
  localparam logic [7:0]  CERR_NVM_BUSY  = 8'hE3;
  localparam logic [15:0] DIAG_SUBFN     = 16'h0000;

  // holding register space
  localparam logic [16:0] REG_ADDR_MAX   = 17'h0_1FFF;
  localparam logic [15:0] RD_CNT_MAX     = 16'h0010;
  localparam logic [15:0] ERR_REG_BASE   = 16'd522;
  localparam int unsigned ERR_REG_NUM    = 11;

  // crc
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;

  // response lengths before the check field
  localparam logic [5:0]  RSP_EXC_LEN    = 6'h03;
  localparam logic [5:0]  RSP_ECHO_LEN   = 6'h06;
  localparam logic [5:0]  RSP_RD_HDR     = 6'h03;

  typedef enum logic [2:0] {
    MRS_RECV  = 3'b000,
    MRS_CHECK = 3'b001,
    MRS_WR    = 3'b010,
    MRS_TX    = 3'b011,
    MRS_RD    = 3'b100
  } mrs_state_t;

  typedef enum logic [1:0] {
    MRS_RSP_READ = 2'b00,
    MRS_RSP_ECHO = 2'b01,
    MRS_RSP_EXC  = 2'b10
  } mrs_rsp_t;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
    logic       parity_err;
  } mrs_rx_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mrs_reg_cmd_t;

  function automatic logic [15:0] mrs_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

/* rtl/mrs_pair_buf.sv */
module mrs_pair_buf
  import mrs_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] ent;
    logic [1:0]        cnt;
  } mrs_buf_st_t;

  mrs_buf_st_t st_ff;
  mrs_buf_st_t nxt_st;
  logic        push;
  logic        pop;

  assign in_ready  = (st_ff.cnt != 2'd2);
  assign out_valid = (st_ff.cnt != 2'd0);
  assign out_data  = st_ff.ent[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (pop) begin
      nxt_st.ent[0] = st_ff.ent[1];
    end
    if (push) begin
      // the word lands behind whatever remains after the pop
      if (st_ff.cnt == 2'd0 || (st_ff.cnt == 2'd1 && pop)) begin
        nxt_st.ent[0] = in_data;
      end else begin
        nxt_st.ent[1] = in_data;
      end
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

endmodule // mrs_pair_buf

/* rtl/mrs_responder.sv */
// Functional notes
// (R1) valid query for this unit that succeeds is executed, then answered normally
// (R2) stop bit read as zero in any character drops query silently
// (R3) parity failure in any character drops query silently
// (R4) crc over whole frame must match check field, else silent drop
// (R5) message longer than 256 bytes is dropped silently
// (R6) broadcast query is executed but never answered
// (R7) address neither own nor broadcast: query ignored, no answer
// (R8) query that cannot execute gets exception frame, same frame layout
// (R9) exception function code is query code plus 80h
// (R10) exception data is one code byte, then crc low byte first
// (R11) unsupported function code gives exception 01h
// (R12) register address beyond 0000h..1FFFh gives exception 02h
// (R13) bad count or length gives exception 03h and records E1h
// (R14) slave failure gives 04h; E2h when disabled, E3h during nvm work
// (R15) recorded error codes read back at registers 522 to 532
// (R16) code 03h reads one to sixteen consecutive registers
// (R17) master sends address, 03h, start, count, crc low first
// (R18) read answer: address, code, byte count, values high first, crc
// (R19) code 06h writes one value to the addressed register
// (R20) addresses 1..31 select a unit, address 0 is broadcast
// (R21) crc starts FFFFh, shifts right, xors A001h on carry
// (R22) frames end after a silent gap of 3.5 characters
// (R23) only 03h, 06h, 08h, 10h accepted; broadcast only for writes (10h is not supported here and gets exception 01h)
module mrs_responder
  import mrs_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = GAP_CYCLES_DEF
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [7:0]   own_addr,
  input  wire logic         cmd_exec_disable,
  input  wire logic         nvm_busy,
  input  wire logic         rx_valid,
  input  wire mrs_rx_t      rx,
  output logic              reg_req,
  output mrs_reg_cmd_t      reg_cmd,
  input  wire logic         reg_ack,
  input  wire logic [15:0]  reg_rdata,
  output logic              tx_valid,
  input  wire logic         tx_ready,
  output logic [7:0]        tx_data,
  output logic              query_drop,
  output logic              query_exec
);

  typedef struct packed {
    mrs_state_t                    fsm;
    mrs_rsp_t                      kind;
    logic [8:0]                    len;
    logic [31:0]                   gap;
    logic                          line_err;
    logic [15:0]                   crc;
    logic [QBUF_BYTES-1:0][7:0]    qbuf;
    logic                          bcast;
    logic [7:0]                    exc_code;
    logic [5:0]                    seq;
    logic [4:0]                    idx;
    logic                          have;
    logic [15:0]                   hold;
    logic [ERR_REG_NUM-1:0][7:0]   hist;
    logic                          drop_p;
    logic                          exec_p;
  } mrs_st_t;

  mrs_st_t     st_ff;
  mrs_st_t     nxt_st;

  logic [7:0]  q_addr;
  logic [7:0]  q_fc;
  logic [15:0] q_start;
  logic [15:0] q_cnt;
  logic [16:0] q_last;
  logic [15:0] rd_addr;
  logic [15:0] err_off;
  logic        rd_internal;
  logic [5:0]  dlen;
  logic [5:0]  dseq;
  logic        need_fetch;
  logic [7:0]  pay;
  logic [7:0]  out_byte;
  logic        buf_ready;
  logic        buf_valid;
  logic        addr_mine;

  assign q_addr  = st_ff.qbuf[0];
  assign q_fc    = st_ff.qbuf[1];
  assign q_start = {st_ff.qbuf[2], st_ff.qbuf[3]};
  assign q_cnt   = {st_ff.qbuf[4], st_ff.qbuf[5]};
  assign q_last  = {1'b0, q_start} + {1'b0, q_cnt} - 17'h0_0001;
  assign rd_addr = q_start + {11'h000, st_ff.idx};
  assign err_off = rd_addr - ERR_REG_BASE;
  // (R15) error history served locally
  assign rd_internal = (rd_addr >= ERR_REG_BASE)
                    && (err_off < 16'(ERR_REG_NUM));

  // (R20) unit address window
  assign addr_mine = (own_addr >= ADDR_UNIT_MIN) && (own_addr <= ADDR_UNIT_MAX)
                  && (q_addr == own_addr);

  always_comb begin
    case (st_ff.kind)
      MRS_RSP_READ: dlen = RSP_RD_HDR + {q_cnt[4:0], 1'b0};
      MRS_RSP_ECHO: dlen = RSP_ECHO_LEN;
      default:      dlen = RSP_EXC_LEN;
    endcase
  end

  assign dseq = st_ff.seq - RSP_RD_HDR;
  assign need_fetch = (st_ff.kind == MRS_RSP_READ) && (st_ff.seq >= RSP_RD_HDR)
                   && (st_ff.seq < dlen) && !dseq[0] && !st_ff.have;

  always_comb begin
    pay = 8'h00;
    case (st_ff.kind)
      // (R18) header, byte count, values high byte first
      MRS_RSP_READ: begin
        if (st_ff.seq == 6'd0) begin
          pay = q_addr;
        end else if (st_ff.seq == 6'd1) begin
          pay = q_fc;
        end else if (st_ff.seq == 6'd2) begin
          pay = {2'b00, q_cnt[4:0], 1'b0};
        end else begin
          pay = dseq[0] ? st_ff.hold[7:0] : st_ff.hold[15:8];
        end
      end
      MRS_RSP_ECHO: pay = st_ff.qbuf[st_ff.seq[2:0]];
      // (R9) exception flag on function code
      MRS_RSP_EXC: begin
        if (st_ff.seq == 6'd0) begin
          pay = q_addr;
        end else if (st_ff.seq == 6'd1) begin
          pay = q_fc + FC_EXC_FLAG;
        end else begin
          pay = st_ff.exc_code;
        end
      end
      default: pay = 8'h00;
    endcase
  end

  // (R10) check field low byte first
  assign out_byte  = (st_ff.seq < dlen) ? pay
                   : (st_ff.seq == dlen) ? st_ff.crc[7:0] : st_ff.crc[15:8];
  assign buf_valid = (st_ff.fsm == MRS_TX) && !need_fetch;

  assign reg_req       = (st_ff.fsm == MRS_WR) || ((st_ff.fsm == MRS_RD) && !rd_internal);
  assign reg_cmd.we    = (st_ff.fsm == MRS_WR);
  assign reg_cmd.addr  = (st_ff.fsm == MRS_WR) ? q_start : rd_addr;
  assign reg_cmd.wdata = q_cnt;
  assign query_drop    = st_ff.drop_p;
  assign query_exec    = st_ff.exec_p;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.drop_p = 1'b0;
    nxt_st.exec_p = 1'b0;
    case (st_ff.fsm)
      MRS_RECV: begin
        if (rx_valid) begin
          nxt_st.gap = 32'h0000_0000;
          // (R5) length saturates one past the limit
          if (st_ff.len <= MSG_LEN_MAX) begin
            nxt_st.len = st_ff.len + 9'h001;
          end
          if (st_ff.len < 9'(QBUF_BYTES)) begin
            nxt_st.qbuf[st_ff.len[2:0]] = rx.data;
          end
          // (R2) (R3) character faults taint the frame
          nxt_st.line_err = st_ff.line_err | rx.frame_err | rx.parity_err;
          // (R21) running crc over every byte
          nxt_st.crc = mrs_crc_byte(st_ff.crc, rx.data);
        end else if (st_ff.len != 9'h000) begin
          nxt_st.gap = st_ff.gap + 32'h0000_0001;
          // (R22) silent gap closes the frame
          if (st_ff.gap >= 32'(GAP_CYCLES - 1)) begin
            nxt_st.fsm = MRS_CHECK;
          end
        end
      end
      MRS_CHECK: begin
        nxt_st.len      = 9'h000;
        nxt_st.gap      = 32'h0000_0000;
        nxt_st.line_err = 1'b0;
        nxt_st.crc      = CRC_INIT;
        nxt_st.seq      = 6'h00;
        nxt_st.idx      = 5'h00;
        nxt_st.have     = 1'b0;
        nxt_st.bcast    = (q_addr == ADDR_BCAST);
        nxt_st.fsm      = MRS_RECV;
        nxt_st.exc_code = 8'h00;
        // (R2) (R3) (R4) (R5) (R7) transmission faults, foreign address
        if (st_ff.line_err || st_ff.len > MSG_LEN_MAX || st_ff.len < MSG_LEN_MIN
            || st_ff.crc != 16'h0000 || !(addr_mine || q_addr == ADDR_BCAST)) begin
          nxt_st.drop_p = 1'b1;
        end else begin
          case (q_fc)
            FC_READ: begin
              // (R23) reads are never broadcast
              if (q_addr == ADDR_BCAST) begin
                nxt_st.drop_p = 1'b1;
              // (R13) (R16) count and length limits
              end else if (st_ff.len != QUERY_LEN || q_cnt == 16'h0000
                           || q_cnt > RD_CNT_MAX) begin
                nxt_st.exc_code = EXC_DATA;
              // (R12) whole span inside the map
              end else if (q_last > REG_ADDR_MAX) begin
                nxt_st.exc_code = EXC_ADDR;
              end else begin
                nxt_st.kind = MRS_RSP_READ;
                nxt_st.fsm  = MRS_TX;
              end
            end
            FC_WRITE: begin
              if (st_ff.len != QUERY_LEN) begin
                nxt_st.exc_code = EXC_DATA;
              end else if ({1'b0, q_start} > REG_ADDR_MAX) begin
                nxt_st.exc_code = EXC_ADDR;
              // (R14) slave side refusals
              end else if (cmd_exec_disable || nvm_busy) begin
                nxt_st.exc_code = EXC_SLAVE;
              end else begin
                // (R19) single register write
                nxt_st.fsm = MRS_WR;
              end
            end
            FC_DIAG: begin
              if (q_addr == ADDR_BCAST) begin
                nxt_st.drop_p = 1'b1;
              end else if (st_ff.len != QUERY_LEN || q_start != DIAG_SUBFN) begin
                nxt_st.exc_code = EXC_DATA;
              end else begin
                nxt_st.kind = MRS_RSP_ECHO;
                nxt_st.fsm  = MRS_TX;
              end
            end
            // (R11) (R23) anything else is unsupported here
            default: nxt_st.exc_code = EXC_FUNC;
          endcase
          if (nxt_st.exc_code != 8'h00) begin
            // (R13) (R14) record communication error, newest at 522
            if (nxt_st.exc_code == EXC_DATA || nxt_st.exc_code == EXC_SLAVE) begin
              for (int i = ERR_REG_NUM - 1; i > 0; i--) begin
                nxt_st.hist[i] = st_ff.hist[i-1];
              end
              nxt_st.hist[0] = (nxt_st.exc_code == EXC_DATA) ? CERR_DATA
                             : cmd_exec_disable ? CERR_DISABLED : CERR_NVM_BUSY;
            end
            // (R6) (R8) exceptions are answered unless broadcast
            nxt_st.kind = MRS_RSP_EXC;
            nxt_st.fsm  = (q_addr == ADDR_BCAST) ? MRS_RECV : MRS_TX;
          end
        end
      end
      MRS_WR: begin
        if (reg_ack) begin
          nxt_st.exec_p = 1'b1;
          nxt_st.kind   = MRS_RSP_ECHO;
          // (R6) broadcast write done, stay silent
          nxt_st.fsm    = st_ff.bcast ? MRS_RECV : MRS_TX;
        end
      end
      MRS_RD: begin
        if (rd_internal) begin
          nxt_st.hold = {8'h00, st_ff.hist[err_off[3:0]]};
          nxt_st.have = 1'b1;
          nxt_st.fsm  = MRS_TX;
        end else if (reg_ack) begin
          nxt_st.hold = reg_rdata;
          nxt_st.have = 1'b1;
          nxt_st.fsm  = MRS_TX;
        end
      end
      MRS_TX: begin
        if (need_fetch) begin
          nxt_st.fsm = MRS_RD;
        end else if (buf_ready) begin
          // (R1) normal or exception frame, stalled by the receiver
          nxt_st.seq = st_ff.seq + 6'h01;
          if (st_ff.seq < dlen) begin
            nxt_st.crc = mrs_crc_byte(st_ff.crc, pay);
          end
          if (st_ff.kind == MRS_RSP_READ && st_ff.seq >= RSP_RD_HDR && dseq[0]) begin
            nxt_st.have = 1'b0;
            nxt_st.idx  = st_ff.idx + 5'h01;
          end
          if (st_ff.seq == dlen + 6'h01) begin
            nxt_st.exec_p = (st_ff.kind == MRS_RSP_READ);
            nxt_st.crc    = CRC_INIT;
            nxt_st.fsm    = MRS_RECV;
          end
        end
      end
      default: nxt_st.fsm = MRS_RECV;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff          <= '0;
      st_ff.fsm      <= MRS_RECV;
      st_ff.crc      <= CRC_INIT;
      st_ff.kind     <= MRS_RSP_READ;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // two words of slack so a stalled line loses nothing
  mrs_pair_buf #(
    .W (8)
  ) u_tx_buf (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   (out_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

endmodule // mrs_responder

/* dv/mrs_responder_props.sv */
module mrs_responder_props
  import mrs_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  input wire logic         ce,
  input wire logic         rx_valid,
  input wire mrs_rx_t      rx,
  input wire logic         reg_req,
  input wire mrs_reg_cmd_t reg_cmd,
  input wire logic         reg_ack,
  input wire logic         tx_valid,
  input wire logic         tx_ready,
  input wire logic [7:0]   tx_data,
  input wire logic         query_drop,
  input wire logic         query_exec
);
  // only errors seen while idle, since busy-time bytes are ignored
  logic err_ff;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || query_drop) begin
      err_ff <= 1'b0;
    end else if (ce && rx_valid && !tx_valid && !reg_req && (rx.frame_err || rx.parity_err)) begin
      err_ff <= 1'b1;
    end
  end

  a_bad_silent: assert property (@(posedge clk_sys) disable iff (sys_rst)
    err_ff |-> !tx_valid && !reg_req) else $error("output after line fault");
  a_write_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req && reg_cmd.we |-> reg_cmd.addr <= 16'h1FFF) else $error("write beyond range");
  a_wr_exec: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req && reg_ack && reg_cmd.we |=> query_exec) else $error("write not committed");
  a_req_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_req && !reg_ack |=> reg_req && $stable(reg_cmd)) else $error("request moved");
  a_tx_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("byte lost");
  a_drop_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    query_drop |=> !query_drop && !query_exec) else $error("drop not a pulse");
  a_exec_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(query_exec) |-> ##1 $fell(query_exec)) else $error("exec not a pulse");
  a_drop_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    query_drop |-> !reg_req ##1 !reg_req [*8]) else $error("access after drop");
  a_reset_quiet: assert property (@(posedge clk_sys)
    sys_rst && ce |=> !tx_valid && !reg_req && !query_drop && !query_exec)
    else $error("outputs active after reset");
endmodule // mrs_responder_props

bind mrs_responder mrs_responder_props u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .rx_valid(rx_valid), .rx(rx),
  .reg_req(reg_req), .reg_cmd(reg_cmd), .reg_ack(reg_ack), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data), .query_drop(query_drop), .query_exec(query_exec)
);

/* dv/mrs_master_model.sv */
module mrs_master_model (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic slow,
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // slow mode stalls about three cycles in four to exercise the buffer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
    end
  end
endmodule // mrs_master_model

/* dv/mrs_responder_tb.sv */
module mrs_responder_tb
  import mrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 20;
  logic         clk_sys = 1'b0;
  logic         sys_rst = 1'b1;
  logic [7:0]   own_addr;
  logic         cmd_exec_disable, nvm_busy, rx_valid, slow;
  logic         reg_ack = 1'b0;
  mrs_rx_t      rx;
  logic         reg_req, tx_valid, tx_ready, query_drop, query_exec;
  mrs_reg_cmd_t reg_cmd;
  logic [15:0]  reg_rdata, w_addr, w_data;
  logic [7:0]   tx_data;
  logic [7:0]   q[$], r[$], exp_q[$];
  int           n_mismatch = 0, n_tests = 0, n_drop = 0, n_exec = 0, e_drop = 0, e_exec = 0;

  always #50 clk_sys = ~clk_sys;

  mrs_responder #(.GAP_CYCLES(GAP)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .own_addr(own_addr),
    .cmd_exec_disable(cmd_exec_disable), .nvm_busy(nvm_busy), .rx_valid(rx_valid), .rx(rx),
    .reg_req(reg_req), .reg_cmd(reg_cmd), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .query_drop(query_drop), .query_exec(query_exec));
  mrs_master_model u_master (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .tx_ready(tx_ready));

  // register store: read data is a fixed function of address
  assign reg_rdata = reg_cmd.addr ^ 16'hA5A5;
  always @(posedge clk_sys) begin
    reg_ack <= reg_req && !reg_ack && ($urandom_range(2) == 0);
    if (reg_req && reg_ack && reg_cmd.we) begin
      w_addr <= reg_cmd.addr;
      w_data <= reg_cmd.wdata;
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  always @(posedge clk_sys) begin
    if (query_drop === 1'b1) n_drop++;
    if (query_exec === 1'b1) n_exec++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      chk({8'h00, tx_data}, exp_q.size() ? {8'h00, exp_q.pop_front()} : 16'h0100);
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic mk(input logic [7:0] ad, input logic [7:0] fc, input logic [15:0] a,
                    input logic [15:0] d);
    q = '{ad, fc, a[15:8], a[7:0], d[15:8], d[7:0]};
  endtask

  task automatic expect_rsp();
    logic [15:0] c;
    c = crc16(r);
    r.push_back(c[7:0]);
    r.push_back(c[15:8]);
    foreach (r[i]) exp_q.push_back(r[i]);
    r.delete();
  endtask

  // check field goes low byte first
  task automatic send(input bit bad_crc, input bit fe, input bit pe);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad_crc};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx <= '{q[i], fe && (i == 2), pe && (i == 3)};
      @(posedge clk_sys);
      rx_valid <= 1'b0;
    end
    q.delete();
  endtask

  task automatic settle();
    int k;
    k = 0;
    repeat (GAP + 4) @(posedge clk_sys);
    while ((exp_q.size() != 0 || tx_valid !== 1'b0 || reg_req !== 1'b0) && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 3000) begin
      chk(16'(k), 16'h0000);
      end_of_test();
    end
    repeat (4) @(posedge clk_sys);
    chk(16'(n_drop), 16'(e_drop));
    chk(16'(n_exec), 16'(e_exec));
  endtask

  task automatic run_exc(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d,
                         input logic [7:0] code);
    mk(own_addr, fc, a, d);
    r = '{own_addr, fc + 8'h80, code};
    expect_rsp();
    send(1'b0, 1'b0, 1'b0);
    settle();
  endtask

  initial begin
    logic [15:0] a, d, n;
    logic [7:0]  fc, code;
    logic [47:0] tbl[9];
    int          i, k;
    tbl = '{{8'h10, 16'h0000, 16'h0001, 8'h01}, {8'h41, 16'h0000, 16'h0001, 8'h01},
            {8'h03, 16'h2000, 16'h0001, 8'h02}, {8'h03, 16'h1FFF, 16'h0002, 8'h02},
            {8'h03, 16'h0000, 16'h0000, 8'h03}, {8'h03, 16'h0000, 16'h0011, 8'h03},
            {8'h06, 16'h2000, 16'h1234, 8'h02}, {8'h06, 16'h0010, 16'h1234, 8'h04},
            {8'h06, 16'h0010, 16'h1234, 8'h04}};
    rx_valid = 1'b0;
    rx = '0;
    cmd_exec_disable = 1'b0;
    nvm_busy = 1'b0;
    slow = 1'b0;
    void'($urandom(32'h8ef2));
    own_addr = 8'($urandom_range(31, 1));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // single write, echoed
    a = 16'($urandom_range(16'h1FFF));
    d = 16'($urandom);
    mk(own_addr, FC_WRITE, a, d);
    r = q;
    e_exec++;
    expect_rsp();
    send(1'b0, 1'b0, 1'b0);
    settle();
    chk(w_addr, a);
    chk(w_data, d);
    slow <= 1'b1;
    // reads: random span, then sixteen at the top of the space
    for (k = 0; k < 2; k++) begin
      n = k ? 16'h0010 : 16'($urandom_range(16, 1));
      // keep clear of the error history, which the store does not model
      a = k ? 16'h1FF0 : 16'($urandom_range(16'h1FFF - n + 1, 16'h0220));
      mk(own_addr, FC_READ, a, n);
      r = '{own_addr, FC_READ, 8'(2 * n)};
      for (i = 0; i < n; i++) begin
        d = (a + 16'(i)) ^ 16'hA5A5;
        r.push_back(d[15:8]);
        r.push_back(d[7:0]);
      end
      e_exec++;
      expect_rsp();
      send(1'b0, 1'b0, 1'b0);
      settle();
    end
    for (i = 0; i < 9; i++) begin
      {fc, a, d, code} = tbl[i];
      nvm_busy <= (i == 7);
      cmd_exec_disable <= (i == 8);
      run_exc(fc, a, d, code);
    end
    cmd_exec_disable <= 1'b0;
    // newest error history entry follows the disabled write
    mk(own_addr, FC_READ, 16'h020A, 16'h0001);
    r = '{own_addr, FC_READ, 8'h02, 8'h00, 8'hE2};
    e_exec++;
    expect_rsp();
    send(1'b0, 1'b0, 1'b0);
    settle();
    // diagnosis echoes subfunction 0000h, else 03h
    d = 16'($urandom);
    mk(own_addr, FC_DIAG, DIAG_SUBFN, d);
    r = q;
    expect_rsp();
    send(1'b0, 1'b0, 1'b0);
    settle();
    run_exc(FC_DIAG, 16'h0001, d, EXC_DATA);
    // silent cases: crc, address, framing, parity, broadcast read, overlong
    for (i = 0; i < 6; i++) begin
      a = 16'($urandom_range(16'h1FFF));
      mk(i == 1 ? own_addr ^ 8'h20 : (i == 4 ? 8'h00 : own_addr),
         i == 4 ? FC_READ : FC_WRITE, a, 16'h0001);
      if (i == 5) repeat (256) q.push_back(8'($urandom));
      e_drop++;
      send(i == 0, i == 2, i == 3);
      settle();
    end
    // broadcast write: executed, never answered
    a = 16'($urandom_range(16'h1FFF));
    d = 16'($urandom);
    mk(8'h00, FC_WRITE, a, d);
    e_exec++;
    send(1'b0, 1'b0, 1'b0);
    settle();
    chk(w_addr, a);
    chk(w_data, d);
    end_of_test();
  end
endmodule // mrs_responder_tb
